// file: core/hbc_bridge_ctrl.sv
// Purpose: mode decode, sleep, lockout and protection of an h-bridge
// Assumes: comparator flags are asynchronous levels, active high
// Notes:   gate outputs are registered; protection overrides decode
`timescale 1ns/1ps
`include "hbc_defs.svh"
module hbc_bridge_ctrl #(
  parameter int SLEEP_CYC  = `HBC_SLEEP_CYC,
  parameter int FILTER_CYC = `HBC_FILTER_CYC,
  parameter int RETRY_CYC  = `HBC_RETRY_CYC,
  parameter int PUMP_CYC   = `HBC_PUMP_CYC
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic srst,
  // control pins
  input  wire logic ctrl_in_a,
  input  wire logic ctrl_in_b,
  // analog comparator flags
  input  wire logic supply_above_on,
  input  wire logic supply_below_off,
  input  wire logic overcurrent_flag,
  input  wire logic short_flag,
  input  wire logic overtemp_flag,
  input  wire logic temp_recovered,
  // bridge switch gates
  output logic      high_switch_a,
  output logic      low_switch_a,
  output logic      high_switch_b,
  output logic      low_switch_b,
  // output drive enables, high while an output is driven
  output logic      bridge_out_a_en,
  output logic      bridge_out_b_en,
  // status
  output logic      pump_enable,
  output logic      asleep,
  output logic      fault_active
);
  localparam int W = 24;

  initial begin
    if (SLEEP_CYC < 1 || FILTER_CYC < 1 || RETRY_CYC < 1 || PUMP_CYC < 1)
      $error("hbc_bridge_ctrl: cycle counts must be at least one");
    if (SLEEP_CYC >= (1 << W) || PUMP_CYC >= (1 << W) ||
        RETRY_CYC >= (1 << W) || FILTER_CYC >= (1 << W))
      $error("hbc_bridge_ctrl: cycle counts too large");
  end

  logic in_a;
  logic in_b;
  logic uv_on;
  logic uv_off;
  logic oc_s;
  logic sc_s;
  logic ot_s;
  logic rec_s;

  // filter bank order: control pins, supply levels, current, temperature
  localparam int                N_PINS    = 8;
  localparam logic [N_PINS-1:0] PIN_RESET = 8'h08; // below-off starts high
  logic [N_PINS-1:0] pin_raw;
  logic [N_PINS-1:0] pin_clean;

  assign pin_raw = {temp_recovered, overtemp_flag, short_flag,
                    overcurrent_flag, supply_below_off, supply_above_on,
                    ctrl_in_b, ctrl_in_a};

  // all asynchronous pins pass the three-flop filter
  for (genvar i = 0; i < N_PINS; i++) begin : g_sync
    hbc_sync #(.RESET_VAL(PIN_RESET[i])) u_sync (
      .clk(clk),
      .srst(srst),
      .pin(pin_raw[i]),
      .level(pin_clean[i])
    );
  end

  // named views of the filtered pins; flags stay active high
  assign in_a   = pin_clean[0];
  assign in_b   = pin_clean[1];
  assign uv_on  = pin_clean[2];
  assign uv_off = pin_clean[3];
  assign oc_s   = pin_clean[4];
  assign sc_s   = pin_clean[5];
  assign ot_s   = pin_clean[6];
  assign rec_s  = pin_clean[7];

  hbc_pkg::hbc_state_type state_q;
  hbc_pkg::hbc_prot_type  prot_q;
  logic                   hot_q;
  logic                   any_in;
  logic                   idle_start;
  logic                   idle_done;
  logic                   pump_start;
  logic                   pump_done;
  logic                   filt_done;
  logic                   retry_start;
  logic                   retry_done;
  logic                   oc_prev_q;
  logic                   idle_run;
  logic                   idle_run_q;

  assign any_in = in_a | in_b;

  // standby means running with both inputs low; any activity ends it
  assign idle_run = (state_q == hbc_pkg::HBC_RUN) && !any_in;

  // idle measurement restarts on every entry into standby
  // faults do not block it, so a tripped idle bridge still falls asleep
  assign idle_start = idle_run && !idle_run_q;

  // remembers last cycle's standby so that a new entry is seen once
  always_ff @(posedge clk) begin
    if (srst)
      idle_run_q <= 1'b0;
    else
      idle_run_q <= idle_run;
  end

  hbc_timer #(.COUNT(SLEEP_CYC), .WIDTH(W)) u_idle (
    .clk(clk),
    .srst(srst),
    .start(idle_start),
    .run(idle_run),
    .done(idle_done)
  );

  // charge pump warm-up after wake or unlock
  assign pump_start = (state_q == hbc_pkg::HBC_LOCKED && uv_on) ||
                      (state_q == hbc_pkg::HBC_SLEEP && any_in);
  hbc_timer #(.COUNT(PUMP_CYC), .WIDTH(W)) u_pump (
    .clk(clk), .srst(srst),
    .start(pump_start),
    .run(state_q == hbc_pkg::HBC_WAKING),
    .done(pump_done));

  // over-current must persist through the filter window
  hbc_timer #(.COUNT(FILTER_CYC), .WIDTH(W)) u_filter (
    .clk(clk), .srst(srst),
    .start(oc_s && !oc_prev_q),
    .run(oc_s && prot_q == hbc_pkg::HBC_PROT_CLEAR),
    .done(filt_done));

  always_ff @(posedge clk) begin
    if (srst)
      oc_prev_q <= 1'b0;
    else
      oc_prev_q <= oc_s;
  end

  // one retry timer serves both over-current and short recheck
  assign retry_start = (prot_q == hbc_pkg::HBC_PROT_CLEAR &&
                        (sc_s || filt_done)) ||
                       (prot_q == hbc_pkg::HBC_PROT_SHORT &&
                        retry_done && sc_s);
  hbc_timer #(.COUNT(RETRY_CYC), .WIDTH(W)) u_retry (
    .clk(clk), .srst(srst),
    .start(retry_start),
    .run(prot_q != hbc_pkg::HBC_PROT_CLEAR),
    .done(retry_done));

  // power and sleep sequencing with lockout hysteresis
  // a supply drop overrides every state, sleep included
  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= hbc_pkg::HBC_LOCKED;
    end else if (uv_off && state_q != hbc_pkg::HBC_LOCKED) begin
      state_q <= hbc_pkg::HBC_LOCKED;
    end else begin
      case (state_q)
        hbc_pkg::HBC_LOCKED:
          if (uv_on)
            state_q <= hbc_pkg::HBC_WAKING;
        hbc_pkg::HBC_WAKING:
          if (pump_done)
            state_q <= hbc_pkg::HBC_RUN;
        hbc_pkg::HBC_RUN:
          if (idle_done)
            state_q <= hbc_pkg::HBC_SLEEP;
        hbc_pkg::HBC_SLEEP:
          if (any_in)
            state_q <= hbc_pkg::HBC_WAKING;
        default:
          state_q <= hbc_pkg::HBC_LOCKED;
      endcase
    end
  end

  // protection latch: short wins, cleared only by its own retry
  // an over-current trip that turns into a short keeps its running retry
  always_ff @(posedge clk) begin
    if (srst) begin
      prot_q <= hbc_pkg::HBC_PROT_CLEAR;
    end else begin
      case (prot_q)
        hbc_pkg::HBC_PROT_CLEAR:
          if (sc_s)
            prot_q <= hbc_pkg::HBC_PROT_SHORT;
          else if (filt_done)
            prot_q <= hbc_pkg::HBC_PROT_OVERCURRENT;
        hbc_pkg::HBC_PROT_OVERCURRENT:
          if (sc_s)
            prot_q <= hbc_pkg::HBC_PROT_SHORT;
          else if (retry_done)
            prot_q <= hbc_pkg::HBC_PROT_CLEAR;
        hbc_pkg::HBC_PROT_SHORT:
          if (retry_done && !sc_s)
            prot_q <= hbc_pkg::HBC_PROT_CLEAR;
        default:
          prot_q <= hbc_pkg::HBC_PROT_CLEAR;
      endcase
    end
  end

  // thermal latch with hysteresis; new heat wins over recovery
  // the flags come from two comparators, so both may read high at once
  always_ff @(posedge clk) begin
    if (srst)
      hot_q <= 1'b0;
    else if (ot_s)
      hot_q <= 1'b1;
    else if (rec_s)
      hot_q <= 1'b0;
  end

  logic drive_ok;
  logic power_ok;
  logic guard_ok;
  logic high_a_d;
  logic low_a_d;
  logic high_b_d;
  logic low_b_d;
  logic en_d;

  // only a running, awake and unlocked bridge may conduct
  assign power_ok = (state_q == hbc_pkg::HBC_RUN);
  // raw short and heat flags act at once, before their latches set
  assign guard_ok = !ot_s && !hot_q && !sc_s &&
                    (prot_q == hbc_pkg::HBC_PROT_CLEAR);
  assign drive_ok = power_ok && guard_ok;

  // next gate pattern; a half never gets both switches
  always_comb begin
    high_a_d = 1'b0;
    low_a_d  = 1'b0;
    high_b_d = 1'b0;
    low_b_d  = 1'b0;
    en_d     = 1'b0;
    if (drive_ok) begin
      case ({in_a, in_b})
        2'b10: begin
          high_a_d = 1'b1;                   // forward
          low_b_d  = 1'b1;
        end
        2'b01: begin
          low_a_d  = 1'b1;                   // reverse
          high_b_d = 1'b1;
        end
        2'b11: begin
          low_a_d  = 1'b1;                   // brake on both low sides
          low_b_d  = 1'b1;
        end
        default: ;                           // standby leaves outputs hi-z
      endcase
      en_d = any_in;
    end
  end

  // gates are registered so decode glitches never reach the switches
  always_ff @(posedge clk) begin
    if (srst) begin
      high_switch_a   <= 1'b0;
      low_switch_a    <= 1'b0;
      high_switch_b   <= 1'b0;
      low_switch_b    <= 1'b0;
      bridge_out_a_en <= 1'b0;
      bridge_out_b_en <= 1'b0;
    end else begin
      high_switch_a   <= high_a_d;
      low_switch_a    <= low_a_d;
      high_switch_b   <= high_b_d;
      low_switch_b    <= low_b_d;
      bridge_out_a_en <= en_d;
      bridge_out_b_en <= en_d;
    end
  end

  // power status; the pump is off whenever the bridge is asleep
  always_ff @(posedge clk) begin
    if (srst) begin
      pump_enable <= 1'b0;
      asleep      <= 1'b0;
    end else begin
      pump_enable <= (state_q == hbc_pkg::HBC_WAKING) ||
                     (state_q == hbc_pkg::HBC_RUN);
      asleep      <= (state_q == hbc_pkg::HBC_SLEEP);
    end
  end

  // fault status covers both latches, not the raw flags
  always_ff @(posedge clk) begin
    if (srst)
      fault_active <= 1'b0;
    else
      fault_active <= hot_q || (prot_q != hbc_pkg::HBC_PROT_CLEAR);
  end
endmodule

// file: shared/hbc_defs.svh
// Purpose: timing constants and the behaviour list of the h-bridge control
// Assumes: 25 MHz core clock
// Notes:   times kept in their own unit; cycle counts derived from them
// Behaviour
// - decode inputs: 00 hi-z, 01 reverse, 10 forward, 11 brake low.
// - enter sleep after both inputs low for sleep entry time, 10 ms.
// - in sleep all blocks off, charge pump off, all switches off.
// - leave sleep when either input goes high, then decode normally.
// - below turn-on supply level outputs hi-z, inputs ignored.
// - inputs govern outputs only after supply rises above turn-on.
// - relock only when supply falls below lower turn-off level.
// - over-current flag held past filter time turns off all switches.
// - after over-current shutdown wait retry time, then resume.
// - short flag acts unfiltered, switches off on first assertion.
// - after short shutdown recheck once per retry period until clear.
// - over-temperature turns switches off until recovery flag shows cool.
// - over-current filter time is 1 us.
// - retry time is 1 ms for over-current and short recheck.
// - on wake allow charge pump 11 ms before bridge operates.
`ifndef HBC_DEFS_SVH
`define HBC_DEFS_SVH
`define HBC_CLK_HZ        25000000
`define HBC_SLEEP_ENTRY_MS 10
`define HBC_FILTER_NS     1000
`define HBC_RETRY_MS      1
`define HBC_PUMP_ON_MS    11
`define HBC_SLEEP_CYC   ((`HBC_CLK_HZ / 1000) * `HBC_SLEEP_ENTRY_MS)
`define HBC_FILTER_CYC  ((`HBC_CLK_HZ / 1000000) * `HBC_FILTER_NS / 1000)
`define HBC_RETRY_CYC   ((`HBC_CLK_HZ / 1000) * `HBC_RETRY_MS)
`define HBC_PUMP_CYC    ((`HBC_CLK_HZ / 1000) * `HBC_PUMP_ON_MS)
`endif

// file: shared/hbc_pkg.sv
// Purpose: types shared by the h-bridge control modules
// Assumes: nothing beyond the defs header
// Notes:   states only; numbers live in the header
package hbc_pkg;
  typedef enum logic [1:0] {
    HBC_LOCKED,
    HBC_WAKING,
    HBC_RUN,
    HBC_SLEEP
  } hbc_state_type;
  typedef enum logic [1:0] {
    HBC_PROT_CLEAR,
    HBC_PROT_OVERCURRENT,
    HBC_PROT_SHORT
  } hbc_prot_type;
endpackage

// file: core/hbc_sync.sv
// Purpose: three-flop synchroniser with agreement filter for one pin
// Assumes: input is asynchronous to clk
// Notes:   the first flop feeds only the second one
`timescale 1ns/1ps
module hbc_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic srst,
  // pin and clean level
  input  wire logic pin,
  output logic      level
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic level_q;

  // shift chain, first stage isolated from any logic
  always_ff @(posedge clk) begin
    if (srst) begin
      s1_q <= RESET_VAL;
      s2_q <= RESET_VAL;
      s3_q <= RESET_VAL;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // a change counts once stages two and three agree
  always_ff @(posedge clk) begin
    if (srst) begin
      level_q <= RESET_VAL;
    end else if (s2_q == s3_q) begin
      level_q <= s3_q;
    end
  end

  assign level = level_q;
endmodule

// file: core/hbc_timer.sv
// Purpose: restartable down counter giving a one-cycle done pulse
// Assumes: start and run come from the same clock
// Notes:   start reloads; dropping run abandons the count
`timescale 1ns/1ps
module hbc_timer #(
  parameter int COUNT = 16,
  parameter int WIDTH = 24
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic srst,
  // control
  input  wire logic start,
  input  wire logic run,
  // result
  output logic      done
);
  logic [WIDTH-1:0] cnt_q;
  logic             busy_q;

  initial begin
    if (COUNT < 1 || COUNT >= (1 << WIDTH))
      $error("hbc_timer: COUNT does not fit WIDTH");
  end

  // load on start, count while run holds, stop at zero
  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_q  <= '0;
      busy_q <= 1'b0;
    end else if (start) begin
      cnt_q  <= WIDTH'(COUNT - 1);
      busy_q <= 1'b1;
    end else if (!run) begin
      busy_q <= 1'b0;
    end else if (busy_q) begin
      if (cnt_q == '0)
        busy_q <= 1'b0;
      else
        cnt_q <= cnt_q - 1'b1;
    end
  end

  assign done = busy_q && run && !start && (cnt_q == '0);
endmodule

// file: verification/hbc_load_model.sv
// Purpose: motor winding model feeding the current comparators
// Assumes: current flows only while a diagonal switch pair conducts
// Notes:   flags follow current, so a tripped bridge clears its own flag
`timescale 1ns/1ps
module hbc_load_model #(
  parameter int LAG = 2
) (
  // clock
  input  wire logic clk,
  // bridge gates
  input  wire logic high_switch_a,
  input  wire logic low_switch_a,
  input  wire logic high_switch_b,
  input  wire logic low_switch_b,
  // fault commands from the bench
  input  wire logic stall,
  input  wire logic shorted,
  // comparator flags
  output logic      overcurrent_flag,
  output logic      short_flag
);
  logic [7:0] amps_q;
  logic       flowing;
  // brake recirculates, so only a diagonal pair draws supply current
  assign flowing = (high_switch_a & low_switch_b) |
                   (high_switch_b & low_switch_a);
  // winding inductance delays the current by LAG cycles
  always_ff @(posedge clk) begin
    amps_q <= {amps_q[6:0], flowing};
  end
  // comparators only see a fault while current actually flows
  assign overcurrent_flag = stall & amps_q[LAG-1];
  assign short_flag       = shorted & amps_q[LAG-1];
endmodule

// file: verification/hbc_bridge_ctrl_asserts.sv
// Purpose: port level checks of the h-bridge control
// Assumes: flags reach the logic within the four cycle input path
// Notes:   held-flag checks wait 8 cycles to cover synchroniser lag
`timescale 1ns/1ps
module hbc_ctrl_asserts #(
  parameter int SLEEP_CYC = 20, FILTER_CYC = 3,
  parameter int RETRY_CYC = 10, PUMP_CYC = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // pins and flags
  input wire logic ctrl_in_a,
  input wire logic ctrl_in_b,
  input wire logic supply_below_off,
  input wire logic short_flag,
  input wire logic overtemp_flag,
  // gates, enables and status
  input wire logic high_switch_a,
  input wire logic low_switch_a,
  input wire logic high_switch_b,
  input wire logic low_switch_b,
  input wire logic bridge_out_a_en,
  input wire logic bridge_out_b_en,
  input wire logic pump_enable,
  input wire logic asleep,
  input wire logic fault_active
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  logic drive_on;
  // any gate on means the bridge is conducting
  assign drive_on = high_switch_a | low_switch_a | high_switch_b |
                    low_switch_b;
  sequence hot_held; overtemp_flag [*8]; endsequence
  sequence low_supply; supply_below_off [*8]; endsequence
  half_a_safe_a: assert property (
    !(high_switch_a && low_switch_a)) else $error("half a both on");
  half_b_safe_a: assert property (
    !(high_switch_b && low_switch_b)) else $error("half b both on");
  sleep_all_off_a: assert property (
    asleep |-> !drive_on && !pump_enable) else $error("awake in sleep");
  sleep_when_idle_a: assert property (
    $rose(asleep) |-> !$past(ctrl_in_a, 6) && !$past(ctrl_in_b, 6))
    else $error("slept with input high");
  supply_lock_hiz_a: assert property (
    low_supply |-> !bridge_out_a_en && !bridge_out_b_en && !drive_on)
    else $error("driven while supply low");
  short_trip_a: assert property (
    $rose(short_flag) |-> ##[1:8] (!drive_on && fault_active))
    else $error("short not acted on");
  hot_trip_a: assert property (
    hot_held |-> !drive_on && fault_active) else $error("hot but on");
  fault_gates_off_a: assert property (
    fault_active && $past(fault_active) |-> !drive_on)
    else $error("gate on during fault");
  enable_follows_a: assert property (
    bridge_out_a_en == (high_switch_a | low_switch_a) &&
    bridge_out_b_en == (high_switch_b | low_switch_b))
    else $error("enable and gates disagree");
  drive_needs_pump_a: assert property (
    drive_on |-> pump_enable && !asleep) else $error("drive without pump");
endmodule
bind hbc_bridge_ctrl hbc_ctrl_asserts #(.SLEEP_CYC(SLEEP_CYC),
  .FILTER_CYC(FILTER_CYC), .RETRY_CYC(RETRY_CYC), .PUMP_CYC(PUMP_CYC))
  hbc_ctrl_asserts_i (.clk, .srst, .ctrl_in_a, .ctrl_in_b,
  .supply_below_off, .short_flag, .overtemp_flag, .high_switch_a,
  .low_switch_a, .high_switch_b, .low_switch_b, .bridge_out_a_en,
  .bridge_out_b_en, .pump_enable, .asleep, .fault_active);

// file: verification/test_hbc_bridge_ctrl.sv
// Purpose: scenario bench of the h-bridge control
// Assumes: short counts so the run stays brief
// Notes:   obs packs asleep, fault, enables a/b and gates ha la hb lb
`timescale 1ns/1ps
module test_hbc_bridge_ctrl;
  localparam int SLP = 20, FLT = 3, RTY = 10, PMP = 8;
  logic clk, srst, ctrl_in_a, ctrl_in_b, supply_above_on, supply_below_off;
  logic overcurrent_flag, short_flag, overtemp_flag, temp_recovered;
  logic high_switch_a, low_switch_a, high_switch_b, low_switch_b;
  logic bridge_out_a_en, bridge_out_b_en, pump_enable, asleep, fault_active;
  logic stall, shorted;
  logic [7:0] obs;
  int   n_errors, comparisons;
  assign obs = {asleep, fault_active, bridge_out_a_en, bridge_out_b_en,
                high_switch_a, low_switch_a, high_switch_b, low_switch_b};
  hbc_bridge_ctrl #(.SLEEP_CYC(SLP), .FILTER_CYC(FLT), .RETRY_CYC(RTY),
    .PUMP_CYC(PMP)) hbc_bridge_ctrl_i (.clk, .srst, .ctrl_in_a, .ctrl_in_b,
    .supply_above_on, .supply_below_off, .overcurrent_flag, .short_flag,
    .overtemp_flag, .temp_recovered, .high_switch_a, .low_switch_a,
    .high_switch_b, .low_switch_b, .bridge_out_a_en, .bridge_out_b_en,
    .pump_enable, .asleep, .fault_active);
  hbc_load_model hbc_load_model_i (.clk, .high_switch_a, .low_switch_a,
    .high_switch_b, .low_switch_b, .stall, .shorted, .overcurrent_flag,
    .short_flag);
  // free running 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // bounded wait; a miss is counted and ends the run
  task automatic wait_obs(input logic [7:0] exp, input int lim);
    for (int i = 0; i < lim && obs !== exp; i++) @(negedge clk);
    check(obs, exp);
    if (obs !== exp) finish_test();
  endtask
  task automatic hold_obs(input logic [7:0] exp, input int n);
    repeat (n) begin
      @(negedge clk);
      check(obs, exp);
    end
  endtask
  task automatic set_in(input logic a, input logic b);
    @(posedge clk);
    ctrl_in_a <= a;
    ctrl_in_b <= b;
  endtask
  task automatic t_lockout;
    set_in(1'b1, 1'b0);
    hold_obs(8'h00, 30);
    @(posedge clk);
    supply_below_off <= 1'b0;
    supply_above_on  <= 1'b1;
    hold_obs(8'h00, PMP);
    wait_obs(8'h39, PMP + 20);
    check({7'h00, pump_enable}, 8'h01);
    $display("lockout done");
  endtask
  task automatic t_modes;
    logic [1:0] code [4] = '{2'b01, 2'b10, 2'b11, 2'b00};
    logic [7:0] want [4] = '{8'h36, 8'h39, 8'h35, 8'h00};
    for (int k = 0; k < 4; k++) begin
      set_in(code[k][1], code[k][0]);
      wait_obs(want[k], 12);
    end
    $display("modes done");
  endtask
  task automatic t_sleep;
    repeat (8) @(posedge clk);
    set_in(1'b0, 1'b1);
    wait_obs(8'h36, 12);
    set_in(1'b0, 1'b0);
    repeat (8) @(posedge clk);
    hold_obs(8'h00, 12);
    wait_obs(8'h80, SLP + 10);
    check({7'h00, pump_enable}, 8'h00);
    set_in(1'b1, 1'b0);
    wait_obs(8'h39, PMP + 20);
    $display("sleep done");
  endtask
  task automatic t_guard;
    @(posedge clk);
    stall <= 1'b1;
    repeat (FLT - 1) @(posedge clk);
    stall <= 1'b0;
    hold_obs(8'h39, 10);
    @(posedge clk);
    stall <= 1'b1;
    wait_obs(8'h40, FLT + 12);
    @(posedge clk);
    stall <= 1'b0;
    hold_obs(8'h40, 4);
    wait_obs(8'h39, RTY + 10);
    @(posedge clk);
    shorted <= 1'b1;
    wait_obs(8'h40, 10);
    repeat (3 * RTY) @(posedge clk);
    shorted <= 1'b0;
    wait_obs(8'h39, 2 * RTY + 10);
    $display("guards done");
  endtask
  task automatic t_thermal;
    @(posedge clk);
    overtemp_flag  <= 1'b1;
    temp_recovered <= 1'b0;
    wait_obs(8'h40, 12);
    @(posedge clk);
    overtemp_flag <= 1'b0;
    hold_obs(8'h40, 20);
    @(posedge clk);
    temp_recovered <= 1'b1;
    wait_obs(8'h39, 12);
    $display("thermal done");
  endtask
  task automatic t_relock;
    @(posedge clk);
    supply_above_on <= 1'b0;
    hold_obs(8'h39, 20);
    @(posedge clk);
    supply_below_off <= 1'b1;
    wait_obs(8'h00, 12);
    set_in(1'b0, 1'b1);
    hold_obs(8'h00, 20);
    $display("relock done");
  endtask
  // power-up values, then each scenario in turn
  initial begin
    {ctrl_in_a, ctrl_in_b, supply_above_on, overtemp_flag} = 4'h0;
    {stall, shorted} = 2'b00;
    supply_below_off = 1'b1;
    temp_recovered   = 1'b1;
    srst = 1'b1;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    t_lockout();
    t_modes();
    t_sleep();
    t_guard();
    t_thermal();
    t_relock();
    finish_test();
  end
endmodule
